// ===== hw/dpb_param_bank.v
// fieldbus parameter bank: read-write parameters plus two read-only status entries
`timescale 1ns/1ps
`include "dpb_consts.vh"
module dpb_param_bank
#(
  parameter NRW = `DPB_NUM_RW
)
(
  input  wire               clk,
  input  wire               reset,
  input  wire               req_valid,
  output wire               req_ready,
  input  wire               req_write,
  input  wire               req_by_object,
  input  wire [15:0]        req_addr,
  input  wire [7:0]         req_class,
  input  wire [7:0]         req_instance,
  input  wire [7:0]         req_attribute,
  input  wire [31:0]        req_wdata,
  output reg                resp_valid,
  output reg                resp_error,
  output reg  [31:0]        resp_rdata,
  input  wire               store_req,
  output reg                store_done,
  input  wire signed [31:0] ref_accel,
  input  wire [7:0]         owner_channel,
  input  wire               owner_exclusive
);
  localparam [1:0] ST_LOAD  = 2'h0;
  localparam [1:0] ST_IDLE  = 2'h1;
  localparam [1:0] ST_STORE = 2'h2;

  // factory image, parameter 0 in the low word
  localparam [4*32-1:0] FACTORY = {`DPB_P3_FACT, `DPB_P2_FACT, `DPB_P1_FACT, `DPB_P0_FACT};

  reg  [1:0]  state_q;
  reg  [2:0]  idx_q;
  reg         load_pend_q;
  reg  [31:0] work_q [0:3];
  reg  [31:0] accel_q;
  reg  [15:0] chan_q;
  wire [31:0] nv_rd_data;
  wire        nv_rd_en;
  wire        nv_wr_en;
  wire [2:0]  sel;
  wire        ok;
  integer     k;

  function [2:0] lookup;
    input        by_obj;
    input [15:0] addr;
    input [23:0] cia;
    begin
      if (by_obj)
      begin
        case (cia)
          `DPB_P0_CIA:    lookup = 3'h0;
          `DPB_P1_CIA:    lookup = 3'h1;
          `DPB_P2_CIA:    lookup = 3'h2;
          `DPB_P3_CIA:    lookup = 3'h3;
          `DPB_CIA_ACCEL: lookup = `DPB_SEL_ACCEL;
          `DPB_CIA_CHAN:  lookup = `DPB_SEL_CHAN;
          default:        lookup = `DPB_SEL_NONE;
        endcase
      end
      else
      begin
        case (addr)
          `DPB_P0_ADDR:    lookup = 3'h0;
          `DPB_P1_ADDR:    lookup = 3'h1;
          `DPB_P2_ADDR:    lookup = 3'h2;
          `DPB_P3_ADDR:    lookup = 3'h3;
          `DPB_ADDR_ACCEL: lookup = `DPB_SEL_ACCEL;
          `DPB_ADDR_CHAN:  lookup = `DPB_SEL_CHAN;
          default:         lookup = `DPB_SEL_NONE;
        endcase
      end
    end
  endfunction

  function is_signed_type;
    input [2:0] t;
    begin
      is_signed_type = (t == `DPB_T_INT8) || (t == `DPB_T_INT16) || (t == `DPB_T_INT32);
    end
  endfunction

  // limits compared in the type's own signedness, the value as a full 32-bit word
  function in_range;
    input [2:0]  t;
    input [31:0] lo;
    input [31:0] hi;
    input [31:0] v;
    begin
      if (is_signed_type(t))
        in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
      else
        in_range = (v >= lo) && (v <= hi);
    end
  endfunction

  function write_ok;
    input [1:0]  i;
    input [31:0] v;
    begin
      case (i)
        2'h0:    write_ok = in_range(`DPB_P0_TYPE, `DPB_P0_MIN, `DPB_P0_MAX, v);
        2'h1:    write_ok = in_range(`DPB_P1_TYPE, `DPB_P1_MIN, `DPB_P1_MAX, v);
        2'h2:    write_ok = in_range(`DPB_P2_TYPE, `DPB_P2_MIN, `DPB_P2_MAX, v);
        default: write_ok = in_range(`DPB_P3_TYPE, `DPB_P3_MIN, `DPB_P3_MAX, v);
      endcase
    end
  endfunction

  function persistent;
    input [1:0] i;
    begin
      case (i)
        2'h0:    persistent = `DPB_P0_PER;
        2'h1:    persistent = `DPB_P1_PER;
        2'h2:    persistent = `DPB_P2_PER;
        default: persistent = `DPB_P3_PER;
      endcase
    end
  endfunction

  assign sel       = lookup(req_by_object, req_addr, {req_class, req_instance, req_attribute});
  assign ok        = write_ok(sel[1:0], req_wdata);
  assign req_ready = (state_q == ST_IDLE);
  assign nv_rd_en  = (state_q == ST_LOAD) && (idx_q < NRW);
  assign nv_wr_en  = (state_q == ST_STORE) && persistent(idx_q[1:0]);

  dpb_nv_mem
  #(
    .W    (32),
    .D    (4),
    .AW   (2),
    .INIT (FACTORY)
  )
  u_nv
  (
    .clk     (clk),
    .rd_en   (nv_rd_en),
    .rd_addr (idx_q[1:0]),
    .rd_data (nv_rd_data),
    .wr_en   (nv_wr_en),
    .wr_addr (idx_q[1:0]),
    .wr_data (work_q[idx_q[1:0]])
  );

  // status entries follow the drive every cycle
  always @(posedge clk)
  begin
    if (reset)
    begin
      accel_q <= `DPB_ACCEL_RST;
      chan_q  <= `DPB_CHAN_RST;
    end
    else
    begin
      accel_q <= ref_accel;
      chan_q  <= {owner_channel, owner_exclusive ? `DPB_USE_EXCLUSIVE : `DPB_USE_SHARED};
    end
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_q     <= ST_LOAD;
      idx_q       <= 3'h0;
      load_pend_q <= 1'b0;
      resp_valid  <= 1'b0;
      resp_error  <= 1'b0;
      resp_rdata  <= 32'h00000000;
      store_done  <= 1'b0;
      for (k = 0; k < 4; k = k + 1)
        work_q[k] <= FACTORY[k*32 +: 32];
    end
    else
    begin
      resp_valid <= 1'b0;
      store_done <= 1'b0;
      case (state_q)
        ST_LOAD:
        begin
          // one cycle of read latency: the word read last cycle lands now
          load_pend_q <= nv_rd_en;
          if (load_pend_q && persistent(idx_q[1:0] - 2'h1))
            work_q[idx_q[1:0] - 2'h1] <= nv_rd_data;
          if (idx_q < NRW)
            idx_q <= idx_q + 3'h1;
          else if (!load_pend_q)
          begin
            idx_q   <= 3'h0;
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          if (req_valid)
          begin
            resp_valid <= 1'b1;
            resp_error <= 1'b0;
            resp_rdata <= 32'h00000000;
            case (sel)
              `DPB_SEL_ACCEL:
              begin
                resp_rdata <= accel_q;
                resp_error <= req_write;
              end
              `DPB_SEL_CHAN:
              begin
                resp_rdata <= {16'h0000, chan_q};
                resp_error <= req_write;
              end
              `DPB_SEL_NONE:
                resp_error <= 1'b1;
              default:
              begin
                if (!req_write)
                  resp_rdata <= work_q[sel[1:0]];
                else if (ok)
                begin
                  work_q[sel[1:0]] <= req_wdata;
                  resp_rdata       <= req_wdata;
                end
                else
                begin
                  resp_rdata <= work_q[sel[1:0]];
                  resp_error <= 1'b1;
                end
              end
            endcase
          end
          else if (store_req)
          begin
            idx_q   <= 3'h0;
            state_q <= ST_STORE;
          end
        end
        ST_STORE:
        begin
          if (idx_q == NRW - 1)
          begin
            idx_q      <= 3'h0;
            store_done <= 1'b1;
            state_q    <= ST_IDLE;
          end
          else
            idx_q <= idx_q + 3'h1;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== hw/dpb_consts.vh
// constants of the drive parameter bank
`ifndef DPB_CONSTS_VH
`define DPB_CONSTS_VH

// fieldbus register addresses of the read-only entries
`define DPB_ADDR_ACCEL       16'h1F12
`define DPB_ADDR_CHAN        16'h0118
// object addresses class.instance.attribute
`define DPB_CIA_ACCEL        24'h830109
`define DPB_CIA_CHAN         24'h65010C
`define DPB_ACCEL_RST        32'h00000000
`define DPB_CHAN_RST         16'h0000

// channel codes carried in the high byte of the owner entry
`define DPB_CH_RESERVED      8'h00
`define DPB_CH_LOCAL_IO      8'h01
`define DPB_CH_PANEL         8'h02
`define DPB_CH_RS485         8'h03
`define DPB_CH_CAN           8'h04
`define DPB_CH_ETHERNET      8'h09
`define DPB_CH_TCP_FIRST     8'h0A
`define DPB_CH_TCP_LAST      8'h0F
`define DPB_USE_SHARED       8'h00
`define DPB_USE_EXCLUSIVE    8'h01

// storage type codes
`define DPB_T_INT8           3'h0
`define DPB_T_UINT8          3'h1
`define DPB_T_INT16          3'h2
`define DPB_T_UINT16         3'h3
`define DPB_T_INT32          3'h4
`define DPB_T_UINT32         3'h5

// read-write parameters: address, object, type, limits, factory, persistence
`define DPB_P0_ADDR          16'h1000
`define DPB_P0_CIA           24'h8C0101
`define DPB_P0_TYPE          `DPB_T_INT16
`define DPB_P0_MIN           32'hFFFF8000
`define DPB_P0_MAX           32'h00007FFF
`define DPB_P0_FACT          32'h00000000
`define DPB_P0_PER           1'b1
`define DPB_P1_ADDR          16'h1002
`define DPB_P1_CIA           24'h8C0102
`define DPB_P1_TYPE          `DPB_T_UINT16
`define DPB_P1_MIN           32'h00000000
`define DPB_P1_MAX           32'h0000FFFF
`define DPB_P1_FACT          32'h00000064
`define DPB_P1_PER           1'b0
`define DPB_P2_ADDR          16'h1004
`define DPB_P2_CIA           24'h8C0103
`define DPB_P2_TYPE          `DPB_T_INT32
`define DPB_P2_MIN           32'hFFFFFC18
`define DPB_P2_MAX           32'h000003E8
`define DPB_P2_FACT          32'h00000032
`define DPB_P2_PER           1'b1
`define DPB_P3_ADDR          16'h1006
`define DPB_P3_CIA           24'h8C0104
`define DPB_P3_TYPE          `DPB_T_UINT32
`define DPB_P3_MIN           32'h00000000
`define DPB_P3_MAX           32'hFFFFFFFF
`define DPB_P3_FACT          32'h00000935
`define DPB_P3_PER           1'b1

// lookup results
`define DPB_SEL_ACCEL        3'h4
`define DPB_SEL_CHAN         3'h5
`define DPB_SEL_NONE         3'h7
`define DPB_NUM_RW           4

`endif

// ===== hw/dpb_nv_mem.v
// nonvolatile image of the persistent parameters
`timescale 1ns/1ps
module dpb_nv_mem
#(
  parameter                 W    = 32,
  parameter                 D    = 4,
  parameter                 AW   = 2,
  parameter [D*W-1:0]       INIT = {D*W{1'b0}}
)
(
  input  wire               clk,
  input  wire               rd_en,
  input  wire [AW-1:0]      rd_addr,
  output reg  [W-1:0]       rd_data,
  input  wire               wr_en,
  input  wire [AW-1:0]      wr_addr,
  input  wire [W-1:0]       wr_data
);
  reg [W-1:0] mem [0:D-1];
  integer     i;

  // contents stand in for cells that outlive power-off, so reset leaves them alone
  initial
  begin
    for (i = 0; i < D; i = i + 1)
      mem[i] = INIT[i*W +: W];
    rd_data = {W{1'b0}};
  end

  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    if (rd_en)
      rd_data <= mem[rd_addr];
  end
endmodule

// ===== dv/dpb_asserts.sv
// assertions on the parameter bank ports
`timescale 1ns/1ps
module dpb_asserts
(
  input logic               clk,
  input logic               reset,
  input logic               req_valid,
  input logic               req_ready,
  input logic               req_write,
  input logic               req_by_object,
  input logic [15:0]        req_addr,
  input logic [7:0]         req_class,
  input logic [7:0]         req_instance,
  input logic [7:0]         req_attribute,
  input logic               resp_valid,
  input logic               resp_error,
  input logic [31:0]        resp_rdata,
  input logic               store_req,
  input logic               store_done,
  input logic signed [31:0] ref_accel
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire take  = req_valid && req_ready;
  wire st_go = store_req && req_ready && !req_valid;
  chk_resp_after_take: assert property (take |=> resp_valid)
    else $error("no response after a taken request");
  chk_no_stray_resp: assert property (resp_valid |-> $past(take))
    else $error("response without request");
  chk_ro_accel_write: assert property (
    take && req_write && !req_by_object && req_addr == 16'h1F12 |=> resp_valid && resp_error)
    else $error("write to acceleration not refused");
  chk_accel_value: assert property (
    take && !req_write && req_by_object && $stable(ref_accel)
    && {req_class, req_instance, req_attribute} == 24'h830109 |=> resp_rdata == $past(ref_accel))
    else $error("acceleration read wrong");
  chk_chan_shape: assert property (
    take && !req_write && !req_by_object && req_addr == 16'h0118
    |=> !resp_error && resp_rdata[31:16] == 16'h0000 && resp_rdata[7:1] == 7'h00)
    else $error("channel entry malformed");
  chk_unmapped_err: assert property (take && !req_by_object && req_addr == 16'h0000 |=> resp_error)
    else $error("unmapped access accepted");
  // four busy cycles, then the registered pulse is seen on the fifth edge
  chk_store_latency: assert property (st_go |-> ##5 store_done)
    else $error("store done late");
  chk_store_busy: assert property (st_go |=> (!req_ready)[*4])
    else $error("ready during store");
  chk_done_cause: assert property (store_done |-> $past(st_go, 5) && !$past(store_done))
    else $error("store done without store");
endmodule
bind dpb_param_bank dpb_asserts u_chk (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
  .req_write(req_write), .req_by_object(req_by_object), .req_addr(req_addr), .req_class(req_class),
  .req_instance(req_instance), .req_attribute(req_attribute), .resp_valid(resp_valid),
  .resp_error(resp_error), .resp_rdata(resp_rdata), .store_req(store_req), .store_done(store_done),
  .ref_accel(ref_accel));

// ===== dv/dpb_master_model.sv
// fieldbus master model driving the request port
`timescale 1ns/1ps
module dpb_master_model
(
  input  logic        clk,
  input  logic        req_ready,
  input  logic        resp_valid,
  input  logic        resp_error,
  input  logic [31:0] resp_rdata,
  input  logic        store_done,
  output logic        req_valid,
  output logic        req_write,
  output logic        req_by_object,
  output logic [15:0] req_addr,
  output logic [23:0] req_obj,
  output logic [31:0] req_wdata,
  output logic        store_req
);
  initial
  begin
    {req_valid, req_write, req_by_object, store_req} = 4'h0;
    {req_addr, req_obj, req_wdata} = 72'h0;
  end
  task automatic xfer(input logic w, bo, input logic [15:0] a, input logic [23:0] o,
                      input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_by_object <= bo;
    {req_addr, req_obj} <= {a, o};
    req_wdata <= d;
    do @(posedge clk); while (!req_ready && ++n < 50);
    req_valid <= 1'b0;
    {req_addr, req_obj, req_wdata} <= ~{a, o, d};
    #1;
    rd = resp_valid ? resp_rdata : 'x;
    er = resp_valid ? resp_error : 1'bx;
  endtask
  // store is only issued by explicit command
  task automatic store(output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    store_req <= 1'b1;
    do @(posedge clk); while (!req_ready && ++n < 50);
    store_req <= 1'b0;
    ok = 1'b0;
    for (int k = 0; k < 8 && !ok; k++)
    begin
      @(posedge clk);
      #1 ok = store_done;
    end
  endtask
endmodule

// ===== dv/dpb_param_bank_tb.sv
// self-checking bench for the parameter bank
`timescale 1ns/1ps
`include "dpb_consts.vh"
module dpb_param_bank_tb;
  logic clk = 0, reset = 1, store_req, store_done, req_valid, req_ready, req_write, req_by_object;
  logic resp_valid, resp_error, owner_exclusive = 0, er, ok;
  logic [15:0] req_addr;
  logic [23:0] req_obj;
  logic [31:0] req_wdata, resp_rdata, rd, rv;
  logic signed [31:0] ref_accel = 0;
  logic [7:0] owner_channel = 0;
  int mismatches = 0, tests_run = 0, cyc = 0;
  logic [31:0] mv[4], nv[4];
  logic [31:0] fact[4] = '{`DPB_P0_FACT, `DPB_P1_FACT, `DPB_P2_FACT, `DPB_P3_FACT};
  logic [15:0] ad[4] = '{`DPB_P0_ADDR, `DPB_P1_ADDR, `DPB_P2_ADDR, `DPB_P3_ADDR};
  logic [23:0] ca[4] = '{`DPB_P0_CIA, `DPB_P1_CIA, `DPB_P2_CIA, `DPB_P3_CIA};
  bit per[4] = '{1, 0, 1, 1};
  bit sg[4] = '{1, 0, 1, 0};
  longint lo[4] = '{-32768, 0, -1000, 0};
  longint hi[4] = '{32767, 65535, 1000, 64'hFFFFFFFF};
  logic [31:0] wv[10] = '{32'h7FFF, 32'h8000, 32'hFFFF8000, 32'hFFFF7FFF, 32'hFFFF, 32'h10000,
                          32'h3E8, 32'h3E9, 32'hFFFFFC17, 32'h32};
  int wi[10] = '{0, 0, 0, 0, 1, 1, 2, 2, 2, 2};
  logic [7:0] codes[7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h09, 8'h0A, 8'h0F};
  always #2 clk = ~clk;
  dpb_param_bank u_dut (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_by_object(req_by_object), .req_addr(req_addr), .req_class(req_obj[23:16]),
    .req_instance(req_obj[15:8]), .req_attribute(req_obj[7:0]), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_error(resp_error), .resp_rdata(resp_rdata), .store_req(store_req),
    .store_done(store_done), .ref_accel(ref_accel), .owner_channel(owner_channel),
    .owner_exclusive(owner_exclusive));
  dpb_master_model u_mst (.clk(clk), .req_ready(req_ready), .resp_valid(resp_valid), .resp_error(resp_error),
    .resp_rdata(resp_rdata), .store_done(store_done), .req_valid(req_valid), .req_write(req_write),
    .req_by_object(req_by_object), .req_addr(req_addr), .req_obj(req_obj), .req_wdata(req_wdata),
    .store_req(store_req));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // range judged on the whole word, so 16-bit signed values arrive sign-extended
  task automatic rw(input bit w, input int i, input logic [31:0] wd, input bit bo);
    longint v;
    bit good;
    v = sg[i] ? longint'($signed(wd)) : longint'(wd);
    good = !w || (v >= lo[i] && v <= hi[i]);
    u_mst.xfer(w, bo, ad[i], ca[i], wd, rd, er);
    if (w && good)
      mv[i] = wd;
    chk("rw_error", {31'h0, er}, {31'h0, !good});
    chk("rw_value", rd, mv[i]);
  endtask
  task automatic ro(input bit w, input bit bo, input bit ch, input logic [31:0] exp);
    u_mst.xfer(w, bo, ch ? `DPB_ADDR_CHAN : `DPB_ADDR_ACCEL, ch ? `DPB_CIA_CHAN : `DPB_CIA_ACCEL, ~exp, rd, er);
    chk("ro_error", {31'h0, er}, {31'h0, w});
    chk("ro_value", rd, exp);
  endtask
  task automatic reboot;
    @(posedge clk);
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
      mv[i] = per[i] ? nv[i] : fact[i];
    for (int i = 0; i < 4; i++)
      rw(0, i, 32'h0, i[0]);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end
  initial
  begin
    rv = $urandom(32'h62C0A7F1);
    nv = fact;
    reboot();
    for (int k = 0; k < 10; k++)
    begin
      rw(1, wi[k], wv[k], k[0]);
      rw(0, wi[k], 32'h0, 0);
    end
    repeat (4) rw(1, 3, $urandom, 0);
    for (int k = 0; k < 7; k++)
    begin
      rv = $urandom;
      @(posedge clk);
      owner_channel <= codes[k];
      owner_exclusive <= k[0];
      ref_accel <= k[0] ? -$signed({1'b0, rv[30:0]}) : $signed({1'b0, rv[30:0]});
      repeat (3) @(posedge clk);
      ro(0, 0, 1, {16'h0, codes[k], 7'h0, k[0]});
      ro(1, 1, 1, {16'h0, codes[k], 7'h0, k[0]});
      ro(0, 1, 0, ref_accel);
      ro(1, 0, 0, ref_accel);
    end
    u_mst.xfer(0, 0, 16'h0000, 24'h0, 32'h0, rd, er);
    chk("unmapped_error", {31'h0, er}, 32'h1);
    rw(1, 0, 32'h1234, 0);
    rw(1, 1, 32'h7, 1);
    u_mst.store(ok);
    chk("store_done", {31'h0, ok}, 32'h1);
    for (int i = 0; i < 4; i++)
      nv[i] = per[i] ? mv[i] : nv[i];
    rw(1, 2, 32'h5, 0);
    reboot();
    complete_run();
  end
endmodule
